//--- common/fsp_defs.vh
// constants for the fault status and nvm program control block
`ifndef FSP_DEFS_VH
`define FSP_DEFS_VH
`define FSP_ADDR_FAULT      8'h54
`define FSP_ADDR_PROG       8'h60
`define FSP_ADDR_UNLOCK     8'h61
`define FSP_RST_FAULT       8'h00
`define FSP_RST_PROG        8'h01
`define FSP_RST_UNLOCK      8'h00
`define FSP_BIT_SHORT       2
`define FSP_BIT_OCP         1
`define FSP_BIT_OTP         0
`define FSP_BIT_DONE        1
`define FSP_CMD_MSB         7
`define FSP_CMD_LSB         3
`define FSP_CMD_PROGRAM     5'h12
`define FSP_UNLOCK_CODE     8'h61
`define FSP_CFG_LAST        4'hb
`define FSP_CLK_KHZ         10000
`define FSP_OCP_US          1000
`define FSP_OTP_US          160
`define FSP_OCP_CYC         ((`FSP_OCP_US * `FSP_CLK_KHZ + 999) / 1000)
`define FSP_OTP_CYC         ((`FSP_OTP_US * `FSP_CLK_KHZ) / 1000 + 1)
`define FSP_HICCUP_CYC      20000
`define FSP_NVM_CYC         64
`endif

//--- logic/fsp_ctrl.v
// fault protection state machine, fault status and nvm program control
`timescale 1ns/1ps
`include "fsp_defs.vh"
module fsp_ctrl #(
   parameter OCP_CYC    = `FSP_OCP_CYC,
   parameter HICCUP_CYC = `FSP_HICCUP_CYC,
   parameter NVM_CYC    = `FSP_NVM_CYC
) (
   // clock and reset
   input  wire       clk,
   input  wire       rst,
   // register port
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   // analog comparators (asynchronous)
   input  wire       uvlo_in,
   input  wire       ocp_in,
   input  wire       scp_in,
   input  wire       otp_in,
   // configuration registers 0x00..0x0b
   input  wire [95:0] cfg_live,
   output reg  [95:0] cfg_reset_value,
   // converter control
   output reg        converter_enable,
   output reg        power_good_output,
   output reg        por_reset
);
   // ================================================================
   // input synchronisers
   // comparator levels are asynchronous to clk; two flops before any use,
   // which costs two cycles of reaction time on every fault, under-voltage
   // included, so the shortest response is three edges after the pin moves
   reg [3:0] sync1;
   reg [3:0] sync2;
   always @(posedge clk) begin
      if (rst) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
      end else begin
         sync1 <= {uvlo_in, ocp_in, scp_in, otp_in};
         sync2 <= sync1;
      end
   end
   wire uvlo = sync2[3];
   wire ocp  = sync2[2];
   wire scp  = sync2[1];
   wire otp  = sync2[0];

   // ================================================================
   // protection state machine
   // under-voltage outranks every other state; a short trips on the first
   // synchronised sample, overload and overheat only after their streaks.
   // retry probes the synchronised comparators for one cycle, so recovery does not
   // wait out a second detection time before the output comes back
   localparam ST_RUN    = 4'b0001;
   localparam ST_HICCUP = 4'b0010;
   localparam ST_RETRY  = 4'b0100;
   localparam ST_UVLO   = 4'b1000;
   reg [3:0]  state;
   reg [15:0] ocp_cnt;
   reg [15:0] otp_cnt;
   reg [15:0] hic_cnt;
   reg        output_overcurrent_flag;
   reg        short_flag;
   reg        thermal_fault_flag;
   wire ocp_trip = ocp && (ocp_cnt >= OCP_CYC[15:0] - 16'h0001);
   // overheat limit held as a 32-bit constant so the compare is cut on purpose
   localparam [31:0] OTP_CYC_ALL = `FSP_OTP_CYC;
   wire otp_trip = otp && (otp_cnt >= OTP_CYC_ALL[15:0] - 16'h0001);
   always @(posedge clk) begin
      if (rst) begin
         state                   <= ST_UVLO;
         ocp_cnt                 <= 16'h0000;
         otp_cnt                 <= 16'h0000;
         hic_cnt                 <= 16'h0000;
         output_overcurrent_flag <= 1'b0;
         short_flag              <= 1'b0;
         thermal_fault_flag      <= 1'b0;
         converter_enable        <= 1'b0;
         power_good_output       <= 1'b0;
         por_reset               <= 1'b1;
      end else begin
         ocp_cnt <= (ocp && state == ST_RUN && !ocp_trip) ? ocp_cnt + 16'h0001 : 16'h0000;
         otp_cnt <= (otp && state == ST_RUN && !otp_trip) ? otp_cnt + 16'h0001 : 16'h0000;
         if (uvlo) begin
            state             <= ST_UVLO;
            por_reset         <= 1'b1;
            converter_enable  <= 1'b0;
            power_good_output <= 1'b0;
         end else begin
            por_reset <= 1'b0;
            case (state)
               ST_UVLO: begin
                  state            <= ST_RUN;
                  converter_enable <= 1'b1;
               end
               ST_RUN: begin
                  power_good_output <= 1'b1;
                  if (scp || ocp_trip || otp_trip) begin
                     state             <= ST_HICCUP;
                     converter_enable  <= 1'b0;
                     power_good_output <= 1'b0;
                     hic_cnt           <= 16'h0000;
                     short_flag              <= scp;
                     output_overcurrent_flag <= ocp_trip;
                     thermal_fault_flag      <= otp_trip;
                  end
               end
               ST_HICCUP: begin
                  power_good_output <= 1'b0;
                  if (hic_cnt >= HICCUP_CYC[15:0] - 16'h0001) begin
                     state            <= ST_RETRY;
                     converter_enable <= 1'b1;
                     hic_cnt          <= 16'h0000;
                  end else begin
                     hic_cnt <= hic_cnt + 16'h0001;
                  end
               end
               ST_RETRY: begin
                  // probe start-up; any fault still present sends it back off
                  if (scp || ocp || otp) begin
                     state            <= ST_HICCUP;
                     converter_enable <= 1'b0;
                  end else begin
                     state                   <= ST_RUN;
                     output_overcurrent_flag <= 1'b0;
                     short_flag              <= 1'b0;
                     thermal_fault_flag      <= 1'b0;
                  end
               end
               default: begin
                  state            <= ST_UVLO;
                  converter_enable <= 1'b0;
               end
            endcase
         end
      end
   end

   // ================================================================
   // nvm program control
   // the unlock key must match at the moment the command lands; a command
   // while busy is dropped rather than queued, and the key clears itself on
   // completion so every program cycle needs a fresh unlock
   reg [4:0]  nvm_program_command;
   reg        nvm_program_done;
   reg [7:0]  nvm_unlock_key;
   reg        prog_busy;
   reg [15:0] nvm_cnt;
   reg [95:0] multi_time_programmable_memory;
   wire       unlocked = (nvm_unlock_key == `FSP_UNLOCK_CODE);
   wire       prog_wr  = reg_wr && reg_addr == `FSP_ADDR_PROG;
   // reset byte of the control register, done bit picked out of it
   localparam [7:0] PROG_RST = `FSP_RST_PROG;
   always @(posedge clk) begin
      if (rst) begin
         nvm_program_command <= 5'h00;
         nvm_program_done    <= PROG_RST[`FSP_BIT_DONE];
         nvm_unlock_key      <= `FSP_RST_UNLOCK;
         prog_busy           <= 1'b0;
         nvm_cnt             <= 16'h0000;
      end else begin
         if (reg_wr && reg_addr == `FSP_ADDR_UNLOCK)
            nvm_unlock_key <= reg_wdata;
         if (prog_wr)
            nvm_program_command <= reg_wdata[`FSP_CMD_MSB:`FSP_CMD_LSB];
         if (prog_wr && unlocked && !prog_busy &&
             reg_wdata[`FSP_CMD_MSB:`FSP_CMD_LSB] == `FSP_CMD_PROGRAM) begin
            prog_busy        <= 1'b1;
            nvm_program_done <= 1'b0;
            nvm_cnt          <= 16'h0000;
         end else if (prog_busy) begin
            if (nvm_cnt >= NVM_CYC[15:0] - 16'h0001) begin
               prog_busy        <= 1'b0;
               nvm_program_done <= 1'b1;
               nvm_unlock_key   <= `FSP_RST_UNLOCK;
            end else begin
               nvm_cnt <= nvm_cnt + 16'h0001;
            end
         end
      end
   end
   // memory content survives reset; it is loaded from cfg_live on the first busy cycle of a program cycle
   always @(posedge clk) begin
      if (prog_busy && nvm_cnt == 16'h0000)
         multi_time_programmable_memory <= cfg_live;
   end
   // reset values are latched from memory while rst or por_reset is held
   always @(posedge clk) begin
      if (rst || por_reset)
         cfg_reset_value <= multi_time_programmable_memory;
   end

   // ================================================================
   // register readback
   // read data is registered and held until the next read strobe,
   // so the host may sample it any time after the answer edge
   always @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `FSP_ADDR_FAULT:
               reg_rdata <= {5'h00, short_flag, output_overcurrent_flag, thermal_fault_flag};
            `FSP_ADDR_PROG:
               reg_rdata <= {nvm_program_command, 1'b0, nvm_program_done, 1'b1};
            `FSP_ADDR_UNLOCK:
               reg_rdata <= nvm_unlock_key;
            default:
               reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule

//--- test/fsp_host.sv
// host model driving the register port
`timescale 1ns/1ps
module fsp_host (
   // clock
   input  wire       clk,
   // register port
   output reg  [7:0] reg_addr,
   output reg  [7:0] reg_wdata,
   output reg        reg_wr,
   output reg        reg_rd,
   input  wire [7:0] reg_rdata
);
   // ==========
   // bus cycles
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      // released data shows garbage, not the last byte
      reg_wdata <= ~d;
   endtask
   task rd(input [7:0] a, output [7:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task prog();
      wr(8'h61, 8'h61);
      wr(8'h60, 8'h90);
   endtask
endmodule

//--- test/fsp_ctrl_sva.sv
// checker for the protection and register ports
`timescale 1ns/1ps
module fsp_ctrl_sva #(parameter OCP_CYC = 20) (
   // clock, reset, register port
   input wire       clk,
   input wire       rst,
   input wire [7:0] reg_addr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   // comparators and converter control
   input wire       uvlo_in,
   input wire       ocp_in,
   input wire       scp_in,
   input wire       otp_in,
   input wire       converter_enable,
   input wire       power_good_output,
   input wire       por_reset
);
   // ==========
   // streak counters, margin covers the input synchronisers
   localparam int OTP_LIM = 1607;
   int ocp_run;
   int otp_run;
   always @(posedge clk) begin
      ocp_run <= (rst || !ocp_in) ? 0 : ocp_run + 1;
      otp_run <= (rst || !otp_in) ? 0 : otp_run + 1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_scp_fast; $rose(scp_in) |-> ##[1:4] !converter_enable; endproperty
   property p_ocp_trip; ocp_run == OCP_CYC + 6 |-> !power_good_output; endproperty
   property p_otp_trip; otp_run == OTP_LIM |-> !power_good_output; endproperty
   property p_uvlo_por; $rose(uvlo_in) |-> ##[1:4] por_reset; endproperty
   property p_uvlo_off; por_reset [*2] |-> !converter_enable && !power_good_output; endproperty
   property p_pg_drop; $fell(converter_enable) |-> ##[0:1] !power_good_output; endproperty
   property p_rd_fault; reg_rd && reg_addr == 8'h54 |=> reg_rdata[7:3] == 5'h00; endproperty
   property p_rd_unmap; reg_rd && reg_addr[7] |=> reg_rdata == 8'h00; endproperty
   property p_rd_hold; !reg_rd |=> $stable(reg_rdata); endproperty
   a_scp_fast: assert property (p_scp_fast) else $error("short left converter on");
   a_ocp_trip: assert property (p_ocp_trip) else $error("overload not shut down");
   a_otp_trip: assert property (p_otp_trip) else $error("overheat not shut down");
   a_uvlo_por: assert property (p_uvlo_por) else $error("no power-on reset");
   a_uvlo_off: assert property (p_uvlo_off) else $error("running in power-on reset");
   a_pg_drop: assert property (p_pg_drop) else $error("power good kept on stop");
   a_rd_fault: assert property (p_rd_fault) else $error("status high bits set");
   a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   c_pg_fell: cover property ($fell(power_good_output));
   c_por: cover property (por_reset ##1 !por_reset);
   c_rd_prog: cover property (reg_rd && reg_addr == 8'h60);
endmodule
bind fsp_ctrl fsp_ctrl_sva #(.OCP_CYC(OCP_CYC)) u_sva (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .uvlo_in(uvlo_in), .ocp_in(ocp_in), .scp_in(scp_in),
   .otp_in(otp_in), .converter_enable(converter_enable), .power_good_output(power_good_output),
   .por_reset(por_reset));

//--- test/fault_status_and_nvm_program_ctrl_test.sv
// self-checking bench for the fault status and nvm program block
`timescale 1ns/1ps
module fault_status_and_nvm_program_ctrl_test;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        uvlo_in = 1'b0;
   logic [2:0]  flt = 3'b000;
   logic [95:0] cfg_live = 96'habaaa9a8a7a6a5a4a3a2a1a0;
   logic [95:0] cfg_rv;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
   logic        reg_wr, reg_rd, conv_en, pg, por;
   int          fails = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   always #50 clk = ~clk;
   fsp_ctrl #(.OCP_CYC(20), .HICCUP_CYC(16), .NVM_CYC(8)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .uvlo_in(uvlo_in),
      .ocp_in(flt[1]), .scp_in(flt[2]), .otp_in(flt[0]), .cfg_live(cfg_live), .cfg_reset_value(cfg_rv),
      .converter_enable(conv_en), .power_good_output(pg), .por_reset(por));
   fsp_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   // ==========
   // helpers
   task summarize();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task cmp(input [7:0] got, input [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk_rd(input [7:0] a, input [7:0] exp, input [7:0] m);
      host.rd(a, d);
      cmp(d & m, exp);
   endtask
   // flag doubles as the comparator pattern: short, overload, overheat
   task fault(input [7:0] flag, input int early, input int late);
      @(posedge clk) flt <= flag[2:0];
      tick(early);
      if (early > 0)
         cmp({7'h00, pg}, 8'h01);
      tick(late);
      cmp({6'h00, conv_en, pg}, 8'h00);
      chk_rd(8'h54, flag, 8'hff);
      tick(60);
      cmp({7'h00, pg}, 8'h00);
      @(posedge clk) flt <= 3'b000;
      tick(45);
      cmp({7'h00, pg}, 8'h01);
      chk_rd(8'h54, 8'h00, 8'hff);
      $display("fault test %h done", flag);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         summarize();
      end
   end
   // ==========
   // sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      tick(3);
      chk_rd(8'h54, 8'h00, 8'hff);
      chk_rd(8'h60, 8'h01, 8'hff);
      chk_rd(8'h61, 8'h00, 8'hff);
      chk_rd(8'h80, 8'h00, 8'hff);
      host.wr(8'h54, 8'hff);
      chk_rd(8'h54, 8'h00, 8'hff);
      host.wr(8'h60, 8'h90);
      tick(12);
      chk_rd(8'h60, 8'h00, 8'h02);
      host.prog();
      chk_rd(8'h60, 8'h00, 8'h02);
      tick(12);
      chk_rd(8'h60, 8'h02, 8'h02);
      chk_rd(8'h61, 8'h00, 8'hff);
      @(posedge clk) cfg_live <= ~cfg_live;
      rst <= 1'b1;
      tick(2);
      @(posedge clk) rst <= 1'b0;
      tick(3);
      for (int i = 0; i < 12; i++)
         cmp(cfg_rv[8*i +: 8], 8'ha0 + i[7:0]);
      $display("register test done");
      fault(8'h04, 0, 5);
      fault(8'h02, 12, 20);
      fault(8'h01, 1500, 150);
      @(posedge clk) uvlo_in <= 1'b1;
      tick(4);
      cmp({6'h00, por, conv_en}, 8'h02);
      @(posedge clk) uvlo_in <= 1'b0;
      tick(10);
      cmp({7'h00, pg}, 8'h01);
      $display("undervoltage test done");
      summarize();
   end
endmodule
